//--- hw/cmsc_top.sv
// Configuration register bank for clock input monitors, fast acquisition and output phase skew.
//
// Overview of operation
// - Bit 0 of the fast acquisition register turns fast acquisition on when set and off when clear.
// - Each input's signal loss select is two bits, the upper bit in register 0x8A and the lower in 0x8B.
// - A select of 00 disables monitoring, 10 picks the slow detector, 11 the normal one, 01 is reserved.
// - The slow detector reacts more slowly and less sensitively than the normal detector.
// - Bits 1 and 0 of register 0x8B enable frequency offset monitoring for inputs two and one.
// - Each output has an eight-bit two's-complement skew counted in high-speed divider clocks.
// - Reset loads 0x0F into the upper signal loss select register.
// - Reset loads 0xFF into the register with the lower select bits and the offset enables.
// - Reset loads 0x00 into the fast acquisition register and both skew registers.
`timescale 1ns/1ps

module cmsc_top
    import cmsc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    output logic      [7:0]        o_rdata,
    output logic                   o_rd_valid,
    output logic                   o_fast_acquire_enable,
    output logic      [1:0]        o_input_one_signal_loss_select,
    output logic      [1:0]        o_input_two_signal_loss_select,
    output logic                   o_input_one_freq_offset_enable,
    output logic                   o_input_two_freq_offset_enable,
    output logic      [1:0]        o_slow_signal_loss_detect_en,
    output logic      [1:0]        o_signal_loss_detect_en,
    output logic      [7:0]        o_output_one_phase_skew,
    output logic      [7:0]        o_output_two_phase_skew
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [7:0] addr8;
    logic       hit_fast;
    logic       hit_los_up;
    logic       hit_mon;
    logic       hit_skew1;
    logic       hit_skew2;
    logic       wr_fast;
    logic       wr_los_up;
    logic       wr_mon;
    logic       wr_skew1;
    logic       wr_skew2;

    assign addr8      = i_addr[7:0];
    assign hit_fast   = (addr8 == CMSC_ADDR_FAST_ACQ);
    assign hit_los_up = (addr8 == CMSC_ADDR_LOS_UPPER);
    assign hit_mon    = (addr8 == CMSC_ADDR_MON_ENABLE);
    assign hit_skew1  = (addr8 == CMSC_ADDR_SKEW_ONE);
    assign hit_skew2  = (addr8 == CMSC_ADDR_SKEW_TWO);
    assign wr_fast    = i_wr_en & hit_fast;
    assign wr_los_up  = i_wr_en & hit_los_up;
    assign wr_mon     = i_wr_en & hit_mon;
    assign wr_skew1   = i_wr_en & hit_skew1;
    assign wr_skew2   = i_wr_en & hit_skew2;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] fast_q;
    logic [7:0] fast_d;
    logic [7:0] los_up_q;
    logic [7:0] los_up_d;
    logic [7:0] mon_q;
    logic [7:0] mon_d;
    logic [7:0] skew1_q;
    logic [7:0] skew1_d;
    logic [7:0] skew2_q;
    logic [7:0] skew2_d;

    assign fast_d = wr_fast
                  ? ((i_wdata & CMSC_MASK_FAST_ACQ) | (CMSC_RST_FAST_ACQ & ~CMSC_MASK_FAST_ACQ))
                  : fast_q;
    assign los_up_d = wr_los_up
                    ? ((i_wdata & CMSC_MASK_LOS_UPPER) | (CMSC_RST_LOS_UPPER & ~CMSC_MASK_LOS_UPPER))
                    : los_up_q;
    assign mon_d = wr_mon
                 ? ((i_wdata & CMSC_MASK_MON_ENABLE) | (CMSC_RST_MON_ENABLE & ~CMSC_MASK_MON_ENABLE))
                 : mon_q;
    assign skew1_d = wr_skew1 ? i_wdata : skew1_q;
    assign skew2_d = wr_skew2 ? i_wdata : skew2_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fast_q <= CMSC_RST_FAST_ACQ;
        end else begin
            fast_q <= fast_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            los_up_q <= CMSC_RST_LOS_UPPER;
        end else begin
            los_up_q <= los_up_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mon_q <= CMSC_RST_MON_ENABLE;
        end else begin
            mon_q <= mon_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            skew1_q <= CMSC_RST_SKEW;
        end else begin
            skew1_q <= skew1_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            skew2_q <= CMSC_RST_SKEW;
        end else begin
            skew2_q <= skew2_d;
        end
    end

    // ------------------------------------------------------------------
    // Field extraction and monitor mode decode
    // ------------------------------------------------------------------
    logic [1:0] los_upper_d;
    logic [1:0] los_lower_d;
    logic [1:0] fos_en_d;
    logic [1:0] slow_en_d;
    logic [1:0] norm_en_d;
    logic [1:0] sel_one_d;
    logic [1:0] sel_two_d;

    assign los_upper_d[0] = los_up_d[CMSC_LOS_UP_ONE_BIT];
    assign los_upper_d[1] = los_up_d[CMSC_LOS_UP_TWO_BIT];
    assign los_lower_d[0] = mon_d[CMSC_LOS_LO_ONE_BIT];
    assign los_lower_d[1] = mon_d[CMSC_LOS_LO_TWO_BIT];
    assign fos_en_d[0]    = mon_d[CMSC_FOS_ONE_BIT];
    assign fos_en_d[1]    = mon_d[CMSC_FOS_TWO_BIT];
    assign sel_one_d      = {los_upper_d[0], los_lower_d[0]};
    assign sel_two_d      = {los_upper_d[1], los_lower_d[1]};

    // Code 01 must never reach the detectors, so it decodes to both off and monitoring stays idle.
    genvar gi;
    generate
        for (gi = 0; gi < CMSC_NUM_INPUTS; gi++) begin : g_los_decode
            logic [1:0] sel;
            assign sel = {los_upper_d[gi], los_lower_d[gi]};
            assign norm_en_d[gi] = (sel == CMSC_LOS_NORMAL);
            assign slow_en_d[gi] = (sel == CMSC_LOS_SLOW);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Reset images of the configuration outputs
    // ------------------------------------------------------------------
    // Derived from the register reset values, so outputs and read-back cannot disagree after reset.
    localparam logic       RST_FAST_EN = CMSC_RST_FAST_ACQ[CMSC_FAST_ACQ_BIT];
    localparam logic [1:0] RST_SEL_ONE = {CMSC_RST_LOS_UPPER[CMSC_LOS_UP_ONE_BIT],
                                          CMSC_RST_MON_ENABLE[CMSC_LOS_LO_ONE_BIT]};
    localparam logic [1:0] RST_SEL_TWO = {CMSC_RST_LOS_UPPER[CMSC_LOS_UP_TWO_BIT],
                                          CMSC_RST_MON_ENABLE[CMSC_LOS_LO_TWO_BIT]};
    localparam logic [1:0] RST_FOS_EN  = {CMSC_RST_MON_ENABLE[CMSC_FOS_TWO_BIT],
                                          CMSC_RST_MON_ENABLE[CMSC_FOS_ONE_BIT]};
    localparam logic [1:0] RST_SLOW_EN = {RST_SEL_TWO == CMSC_LOS_SLOW, RST_SEL_ONE == CMSC_LOS_SLOW};
    localparam logic [1:0] RST_NORM_EN = {RST_SEL_TWO == CMSC_LOS_NORMAL, RST_SEL_ONE == CMSC_LOS_NORMAL};

    // ------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------
    logic       fast_en_q;
    logic [1:0] sel_one_q;
    logic [1:0] sel_two_q;
    logic [1:0] fos_en_q;
    logic [1:0] slow_en_q;
    logic [1:0] norm_en_q;

    // The outputs follow the storage from the same edge, so the decode costs no extra latency.
    // fast acquisition enable
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fast_en_q <= RST_FAST_EN;
        end else begin
            fast_en_q <= fast_d[CMSC_FAST_ACQ_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sel_one_q <= RST_SEL_ONE;
        end else begin
            sel_one_q <= sel_one_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sel_two_q <= RST_SEL_TWO;
        end else begin
            sel_two_q <= sel_two_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fos_en_q <= RST_FOS_EN;
        end else begin
            fos_en_q <= fos_en_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            slow_en_q <= RST_SLOW_EN;
        end else begin
            slow_en_q <= slow_en_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            norm_en_q <= RST_NORM_EN;
        end else begin
            norm_en_q <= norm_en_d;
        end
    end

    assign o_fast_acquire_enable          = fast_en_q;
    assign o_input_one_signal_loss_select = sel_one_q;
    assign o_input_two_signal_loss_select = sel_two_q;
    assign o_input_one_freq_offset_enable = fos_en_q[0];
    assign o_input_two_freq_offset_enable = fos_en_q[1];
    assign o_slow_signal_loss_detect_en   = slow_en_q;
    assign o_signal_loss_detect_en        = norm_en_q;
    assign o_output_one_phase_skew        = skew1_q;
    assign o_output_two_phase_skew        = skew2_q;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;
    logic       rd_valid_q;

    // A read in the same cycle as a write to that register returns the old contents.
    // reserved bits read reset
    assign rd_mux = hit_fast   ? fast_q   :
                    hit_los_up ? los_up_q :
                    hit_mon    ? mon_q    :
                    hit_skew1  ? skew1_q  :
                    hit_skew2  ? skew2_q  :
                    CMSC_UNMAPPED_DATA;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en;
        end
    end

    // The read data holds until the next read, so a slow host may still pick it up late.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= CMSC_UNMAPPED_DATA;
        end else if (i_rd_en) begin
            rdata_q <= rd_mux;
        end
    end

    assign o_rdata    = rdata_q;
    assign o_rd_valid = rd_valid_q;

endmodule : cmsc_top

//--- pkg/cmsc_pkg.sv
// Package with the register map, field positions and reset values of the clock monitor and skew bank.
package cmsc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CMSC_ADDR_FAST_ACQ   = 8'h89;
    localparam logic [7:0] CMSC_ADDR_LOS_UPPER  = 8'h8A;
    localparam logic [7:0] CMSC_ADDR_MON_ENABLE = 8'h8B;
    localparam logic [7:0] CMSC_ADDR_SKEW_ONE   = 8'h8E;
    localparam logic [7:0] CMSC_ADDR_SKEW_TWO   = 8'h8F;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CMSC_RST_FAST_ACQ    = 8'h00;
    localparam logic [7:0] CMSC_RST_LOS_UPPER   = 8'h0F;
    localparam logic [7:0] CMSC_RST_MON_ENABLE  = 8'hFF;
    localparam logic [7:0] CMSC_RST_SKEW        = 8'h00;
    localparam logic [7:0] CMSC_UNMAPPED_DATA   = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CMSC_FAST_ACQ_BIT   = 0;
    localparam int CMSC_LOS_UP_ONE_BIT = 0;
    localparam int CMSC_LOS_UP_TWO_BIT = 1;
    localparam int CMSC_LOS_LO_ONE_BIT = 4;
    localparam int CMSC_LOS_LO_TWO_BIT = 5;
    localparam int CMSC_FOS_ONE_BIT    = 0;
    localparam int CMSC_FOS_TWO_BIT    = 1;

    // Writable bits of registers 0x89, 0x8A and 0x8B; the rest hold their reset value.
    localparam logic [7:0] CMSC_MASK_FAST_ACQ   = 8'h01;
    localparam logic [7:0] CMSC_MASK_LOS_UPPER  = 8'h03;
    localparam logic [7:0] CMSC_MASK_MON_ENABLE = 8'h33;

    // ------------------------------------------------------------------
    // Signal loss monitor select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] CMSC_LOS_OFF      = 2'h0;
    localparam logic [1:0] CMSC_LOS_RESERVED = 2'h1;
    localparam logic [1:0] CMSC_LOS_SLOW     = 2'h2;
    localparam logic [1:0] CMSC_LOS_NORMAL   = 2'h3;

    localparam int CMSC_NUM_INPUTS = 2;

endpackage : cmsc_pkg

//--- sim/cmsc_props.sv
// Concurrent checks on the ports of the clock monitor and skew configuration bank.
`timescale 1ns/1ps
module cmsc_props #(
    parameter int ADDR_W = 8
) (
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire logic              i_wr_en,
    input wire logic              i_rd_en,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0]        i_wdata,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_rd_valid,
    input wire logic              o_fast_acquire_enable,
    input wire logic [1:0]        o_input_one_signal_loss_select,
    input wire logic [1:0]        o_input_two_signal_loss_select,
    input wire logic              o_input_one_freq_offset_enable,
    input wire logic              o_input_two_freq_offset_enable,
    input wire logic [1:0]        o_slow_signal_loss_detect_en,
    input wire logic [1:0]        o_signal_loss_detect_en,
    input wire logic [7:0]        o_output_one_phase_skew,
    input wire logic [7:0]        o_output_two_phase_skew
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_fast;
        i_wr_en && i_addr == 8'h89 |=> o_fast_acquire_enable == $past(i_wdata[0]);
    endproperty
    a_fast: assert property (p_fast) else $error("fast acquire enable not taken");
    property p_upper;
        i_wr_en && i_addr == 8'h8A |=>
            {o_input_two_signal_loss_select[1], o_input_one_signal_loss_select[1]} == $past(i_wdata[1:0]);
    endproperty
    a_upper: assert property (p_upper) else $error("upper select bits not taken");
    property p_lower;
        i_wr_en && i_addr == 8'h8B |=> {o_input_two_signal_loss_select[0], o_input_one_signal_loss_select[0],
            o_input_two_freq_offset_enable, o_input_one_freq_offset_enable} == {$past(i_wdata[5:4]), $past(i_wdata[1:0])};
    endproperty
    a_lower: assert property (p_lower) else $error("lower select or offset enables not taken");
    property p_decode;
        o_slow_signal_loss_detect_en == {o_input_two_signal_loss_select == 2'h2, o_input_one_signal_loss_select == 2'h2}
        && o_signal_loss_detect_en == {o_input_two_signal_loss_select == 2'h3, o_input_one_signal_loss_select == 2'h3};
    endproperty
    a_decode: assert property (p_decode) else $error("detector enables disagree with select");
    property p_skew_one;
        i_wr_en && i_addr == 8'h8E |=> o_output_one_phase_skew == $past(i_wdata);
    endproperty
    a_skew_one: assert property (p_skew_one) else $error("output one skew not taken");
    property p_skew_two;
        i_wr_en && i_addr == 8'h8F |=> o_output_two_phase_skew == $past(i_wdata);
    endproperty
    a_skew_two: assert property (p_skew_two) else $error("output two skew not taken");
    property p_reset;
        disable iff (1'b0) !i_rst_n |=> !o_fast_acquire_enable && o_input_one_signal_loss_select == 2'h3
            && o_input_two_signal_loss_select == 2'h3 && o_input_one_freq_offset_enable
            && o_input_two_freq_offset_enable && o_output_one_phase_skew == 8'h00 && o_output_two_phase_skew == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not at reset values");
    property p_reserved;
        i_rd_en && i_addr == 8'h8A |=> o_rd_valid && o_rdata[7:2] == 6'h03;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read wrong");
    c_slow: cover property (o_slow_signal_loss_detect_en != 2'h0);
    c_neg: cover property (o_output_one_phase_skew[7]);
    c_unmapped: cover property (i_rd_en && i_addr == 8'h8C ##1 o_rd_valid);
endmodule : cmsc_props

bind cmsc_top cmsc_props #(.ADDR_W(ADDR_W)) cmsc_props_i (.*);

//--- sim/test_clock_monitor_skew_config.sv
// Self-checking testbench for the clock monitor and skew configuration bank.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; \
    if ((got) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module test_clock_monitor_skew_config
    import cmsc_pkg::*;
;
    logic       i_clk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       i_wr_en = 1'b0;
    logic       i_rd_en = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata, o_output_one_phase_skew, o_output_two_phase_skew;
    logic [1:0] o_input_one_signal_loss_select, o_input_two_signal_loss_select, c1, c2;
    logic [1:0] o_slow_signal_loss_detect_en, o_signal_loss_detect_en;
    logic       o_rd_valid, o_fast_acquire_enable, o_input_one_freq_offset_enable, o_input_two_freq_offset_enable;
    logic [7:0] sk [3] = '{8'h80, 8'h7F, 8'hF6};
    logic [1:0] codes [3] = '{CMSC_LOS_OFF, CMSC_LOS_SLOW, CMSC_LOS_NORMAL};
    int         error_cnt = 0;
    int         total_checks = 0;

    cmsc_top cmsc_top_i (.*);

    always #2.5 i_clk = ~i_clk;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_wr_en = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        @(negedge i_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        i_rd_en = 1'b1;
        i_addr = a;
        @(negedge i_clk);
        i_rd_en = 1'b0;
        `CHK("rd_valid", 1'b1, o_rd_valid)
        `CHK("rdata", ex, o_rdata)
        @(negedge i_clk);
    endtask : rd

    task automatic dflt();
        rd(8'h89, CMSC_RST_FAST_ACQ);
        rd(8'h8A, 8'h0F);
        rd(8'h8B, 8'hFF);
        rd(8'h8E, 8'h00);
        rd(8'h8F, 8'h00);
        `CHK("skews", 16'h0000, {o_output_two_phase_skew, o_output_one_phase_skew})
        `CHK("loss_en", 2'h3, o_signal_loss_detect_en)
        `CHK("slow_en", 2'h0, o_slow_signal_loss_detect_en)
        `CHK("fast_rst", 1'b0, o_fast_acquire_enable)
    endtask : dflt

    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // The whole sequence needs about 90 cycles, so 20 us is a generous limit.
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        dflt();
        wr(8'h89, 8'hFF);
        rd(8'h89, 8'h01);
        `CHK("fast", 1'b1, o_fast_acquire_enable)
        wr(8'h89, 8'hFE);
        `CHK("fast", 1'b0, o_fast_acquire_enable)
        wr(8'h8C, 8'h55);
        rd(8'h8C, CMSC_UNMAPPED_DATA);
        // reserved code avoided
        // Lower register first, so no select ever passes through the reserved code on the way.
        for (int k = 0; k < 3; k++) begin
            c1 = codes[k];
            c2 = codes[(k + 1) % 3];
            wr(8'h8B, {2'h0, c2[0], c1[0], 2'h0, c1});
            wr(8'h8A, {6'h3F, c2[1], c1[1]});
            rd(8'h8A, {6'h03, c2[1], c1[1]});
            rd(8'h8B, {2'h3, c2[0], c1[0], 2'h3, c1});
            `CHK("sel", {c2, c1}, {o_input_two_signal_loss_select, o_input_one_signal_loss_select})
            `CHK("slow", {c2 == CMSC_LOS_SLOW, c1 == CMSC_LOS_SLOW}, o_slow_signal_loss_detect_en)
            `CHK("normal", {c2 == CMSC_LOS_NORMAL, c1 == CMSC_LOS_NORMAL}, o_signal_loss_detect_en)
            `CHK("fos", c1, {o_input_two_freq_offset_enable, o_input_one_freq_offset_enable})
        end
        foreach (sk[i]) begin
            wr(8'h8E, sk[i]);
            wr(8'h8F, ~sk[i]);
            rd(8'h8E, sk[i]);
            rd(8'h8F, ~sk[i]);
            `CHK("skew1", sk[i], o_output_one_phase_skew)
            `CHK("skew2", ~sk[i], o_output_two_phase_skew)
        end
        // A second reset must bring back every default after non-default writes.
        i_rst_n = 1'b0;
        @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        dflt();
        end_sim();
    end
endmodule : test_clock_monitor_skew_config
